// ### logic/tao_alarm_top.v
// Alarm and fail-safe output logic of a two-channel temperature monitor.
// Assumes an upstream serial engine decodes register accesses and the
// alert response read, and a converter that reports each result.
`timescale 1ns/1ps
`include "tao_defs.vh"

module tao_alarm_top #(
   parameter       W           = 8,
   parameter [6:0] DEV_ADDR    = 7'h4C,
   parameter       TMO_CYCLES  = `TAO_BUS_TMO_CYC
) (
   // Clock and reset
   input  wire         clock_in,
   input  wire         resetn_in,
   // Decoded register writes
   input  wire         wr_stb_in,
   input  wire [7:0]   wr_addr_in,
   input  wire [7:0]   wr_data_in,
   // Decoded register reads
   input  wire         rd_stb_in,
   input  wire [7:0]   rd_addr_in,
   output reg  [7:0]   rd_data_out,
   // Alert response read
   input  wire         ara_req_in,
   input  wire         ara_lost_in,
   input  wire         ara_done_in,
   output wire         ara_ack_out,
   output reg  [7:0]   ara_byte_out,
   // Bus activity for timeout
   input  wire         bus_busy_in,
   input  wire         bus_edge_in,
   output reg          bus_timeout_out,
   // Converter
   output reg          conv_start_out,
   output reg          conv_abort_out,
   input  wire         conv_done_in,
   input  wire [W-1:0] local_temp_in,
   input  wire [W-1:0] remote_temp_in,
   input  wire         open_fault_in,
   // Open-drain pins
   output wire         alarm_pin_o_out,
   output wire         alarm_pin_oe_out,
   output wire         overtemp_failsafe_n_o_out,
   output wire         overtemp_failsafe_n_oe_out
);

   // ****************************************************************
   // Sequencer states
   // ****************************************************************
   localparam [1:0] S_IDLE = 2'b01;
   localparam [1:0] S_CONV = 2'b10;

   reg  [1:0]   state_q;
   reg          one_shot_q;
   reg  [7:0]   config_q;
   reg  [7:0]   consec_q;
   reg  [W-1:0] loc_high_q, loc_low_q, rem_high_q, rem_low_q;
   reg  [W-1:0] loc_fs_q, rem_fs_q, hyst_q;
   reg  [W-1:0] loc_val_q, rem_val_q;
   reg          open_seen_q;
   reg  [7:0]   status_q;
   reg          alert_q;
   reg          addr_fetched_q;
   reg  [31:0]  tmo_cnt_q;

   wire standby   = config_q[`TAO_CFG_STANDBY_BIT];
   wire masked    = config_q[`TAO_CFG_MASK_BIT];
   wire pin_fs2   = config_q[`TAO_CFG_PINMODE_BIT];
   wire tmo_en    = consec_q[`TAO_CON_TMO_EN_BIT];
   wire trig_wr   = wr_stb_in & (wr_addr_in == `TAO_WA_ONE_SHOT);
   wire limit_wr  = wr_stb_in & ((wr_addr_in == `TAO_WA_LOC_HIGH) |
                                 (wr_addr_in == `TAO_WA_LOC_LOW)  |
                                 (wr_addr_in == `TAO_WA_REM_HIGH) |
                                 (wr_addr_in == `TAO_WA_REM_LOW));
   wire stat_rd   = rd_stb_in & (rd_addr_in == `TAO_RA_STATUS);
   wire standby_abort = standby & ~one_shot_q;
   wire conv_end  = (state_q == S_CONV) & conv_done_in & ~standby_abort;

   // ****************************************************************
   // Configuration and limit registers
   // ****************************************************************
   always @(posedge clock_in) begin
      if (!resetn_in) begin
         config_q   <= `TAO_RST_CONFIG;
         consec_q   <= `TAO_RST_CONSEC;
         loc_high_q <= `TAO_RST_LOC_HIGH;
         loc_low_q  <= `TAO_RST_LOC_LOW;
         rem_high_q <= `TAO_RST_REM_HIGH;
         rem_low_q  <= `TAO_RST_REM_LOW;
         loc_fs_q   <= `TAO_RST_FS_LIM;
         rem_fs_q   <= `TAO_RST_FS_LIM;
         hyst_q     <= `TAO_RST_FS_HYST;
      end else if (wr_stb_in) begin
         case (wr_addr_in)
            `TAO_WA_CONFIG:     config_q   <= wr_data_in;
            `TAO_WA_CONSEC:     consec_q   <= wr_data_in;
            `TAO_WA_LOC_HIGH:   loc_high_q <= wr_data_in;
            `TAO_WA_LOC_LOW:    loc_low_q  <= wr_data_in;
            `TAO_WA_REM_HIGH:   rem_high_q <= wr_data_in;
            `TAO_WA_REM_LOW:    rem_low_q  <= wr_data_in;
            `TAO_WA_LOC_FS_LIM: loc_fs_q   <= wr_data_in;
            `TAO_WA_REM_FS_LIM: rem_fs_q   <= wr_data_in;
            `TAO_WA_FS_HYST:    hyst_q     <= wr_data_in;
            default: ;
         endcase
      end
   end

   // ****************************************************************
   // Conversion sequencer
   // ****************************************************************
   // Free-running unless in standby; a trigger write in standby runs
   // one pass and the sequencer falls back to idle.
   always @(posedge clock_in) begin
      if (!resetn_in) begin
         state_q        <= S_IDLE;
         one_shot_q     <= 1'b0;
         conv_start_out <= 1'b0;
         conv_abort_out <= 1'b0;
         open_seen_q    <= 1'b0;
      end else begin
         conv_start_out <= 1'b0;
         conv_abort_out <= 1'b0;
         case (state_q)
            S_IDLE: begin
               if (!standby || trig_wr) begin
                  one_shot_q     <= standby;
                  conv_start_out <= 1'b1;
                  open_seen_q    <= open_fault_in;
                  state_q        <= S_CONV;
               end
            end
            S_CONV: begin
               if (standby_abort) begin
                  conv_abort_out <= 1'b1;
                  state_q        <= S_IDLE;
               end else if (conv_done_in) begin
                  one_shot_q <= 1'b0;
                  state_q    <= S_IDLE;
               end
            end
            default: state_q <= S_IDLE;
         endcase
      end
   end

   // Value registers change only on a finished, unaborted conversion
   always @(posedge clock_in) begin
      if (!resetn_in) begin
         loc_val_q <= {W{1'b0}};
         rem_val_q <= {W{1'b0}};
      end else if (conv_end) begin
         loc_val_q <= local_temp_in;
         rem_val_q <= remote_temp_in;
      end
   end

   // ****************************************************************
   // Limit comparison and status
   // ****************************************************************
   wire [W-1:0] loc_t = conv_end ? local_temp_in  : loc_val_q;
   wire [W-1:0] rem_t = conv_end ? remote_temp_in : rem_val_q;
   reg  [7:0]   viol;

   always @* begin
      viol = 8'h00;
      viol[`TAO_ST_LOC_HIGH] = loc_t > loc_high_q;
      viol[`TAO_ST_LOC_LOW]  = loc_t <= loc_low_q;
      viol[`TAO_ST_REM_HIGH] = rem_t > rem_high_q;
      viol[`TAO_ST_REM_LOW]  = rem_t <= rem_low_q;
      viol[`TAO_ST_OPEN]     = open_seen_q;
   end

   // Limit-write check waits one cycle so it sees the new limit
   reg  limit_chk_q;
   wire eval = conv_end | limit_chk_q;

   always @(posedge clock_in) begin
      if (!resetn_in) begin
         limit_chk_q <= 1'b0;
      end else begin
         limit_chk_q <= limit_wr;
      end
   end

   // Set beats the read-clear in the same cycle
   always @(posedge clock_in) begin
      if (!resetn_in) begin
         status_q <= 8'h00;
      end else begin
         status_q <= (stat_rd ? 8'h00 : status_q) | (eval ? viol : 8'h00);
      end
   end

   // ****************************************************************
   // Maskable alarm and alert response
   // ****************************************************************
   wire cause_now = |(viol & ~(8'h01 << `TAO_ST_OPEN)) | open_seen_q;
   wire raise     = eval & (|viol) & ~masked;

   always @(posedge clock_in) begin
      if (!resetn_in) begin
         alert_q        <= 1'b0;
         addr_fetched_q <= 1'b0;
         ara_byte_out   <= 8'h00;
      end else begin
         if (ara_req_in && alert_q && !pin_fs2) begin
            ara_byte_out <= {DEV_ADDR, 1'b1};
         end
         if (raise) begin
            alert_q        <= 1'b1;
            addr_fetched_q <= 1'b0;
         end else if (alert_q) begin
            // A lost arbitration is not a fetch, alarm stays
            if (ara_done_in && !ara_lost_in) begin
               addr_fetched_q <= 1'b1;
            end
            if ((addr_fetched_q || (ara_done_in && !ara_lost_in)) &&
                !cause_now && (status_q == 8'h00 || stat_rd)) begin
               alert_q        <= 1'b0;
               addr_fetched_q <= 1'b0;
            end
         end
      end
   end

   // Host keeps re-reading while the shared line stays low
   assign ara_ack_out = ara_req_in & alert_q & ~pin_fs2;

   // ****************************************************************
   // Fail-safe comparators
   // ****************************************************************
   wire fs_loc, fs_rem, fs2_loc, fs2_rem;

   tao_hyst_cmp #(.W(W)) u_fs_loc (
      .clock_in  (clock_in),
      .resetn_in (resetn_in),
      .update_in (conv_end),
      .temp_in   (local_temp_in),
      .limit_in  (loc_fs_q),
      .hyst_in   (hyst_q),
      .trip_out  (fs_loc)
   );

   tao_hyst_cmp #(.W(W)) u_fs_rem (
      .clock_in  (clock_in),
      .resetn_in (resetn_in),
      .update_in (conv_end),
      .temp_in   (remote_temp_in),
      .limit_in  (rem_fs_q),
      .hyst_in   (hyst_q),
      .trip_out  (fs_rem)
   );

   tao_hyst_cmp #(.W(W)) u_fs2_loc (
      .clock_in  (clock_in),
      .resetn_in (resetn_in),
      .update_in (conv_end),
      .temp_in   (local_temp_in),
      .limit_in  (loc_high_q),
      .hyst_in   (hyst_q),
      .trip_out  (fs2_loc)
   );

   tao_hyst_cmp #(.W(W)) u_fs2_rem (
      .clock_in  (clock_in),
      .resetn_in (resetn_in),
      .update_in (conv_end),
      .temp_in   (remote_temp_in),
      .limit_in  (rem_high_q),
      .hyst_in   (hyst_q),
      .trip_out  (fs2_rem)
   );

   // ****************************************************************
   // Pin drive
   // ****************************************************************
   // Enables are flops; only the alarm enable is gated by config bits, so only the alarm pin also moves on config writes
   wire fs2_any = fs2_loc | fs2_rem;

   assign overtemp_failsafe_n_o_out  = 1'b0;
   assign overtemp_failsafe_n_oe_out = fs_loc | fs_rem;
   assign alarm_pin_o_out            = 1'b0;
   assign alarm_pin_oe_out           = pin_fs2 ? fs2_any : (alert_q & ~masked);

   // ****************************************************************
   // Bus timeout
   // ****************************************************************
   always @(posedge clock_in) begin
      if (!resetn_in) begin
         tmo_cnt_q       <= 32'h0000_0000;
         bus_timeout_out <= 1'b0;
      end else begin
         bus_timeout_out <= 1'b0;
         if (!tmo_en || !bus_busy_in || bus_edge_in) begin
            tmo_cnt_q <= 32'h0000_0000;
         end else if (tmo_cnt_q == TMO_CYCLES - 1) begin
            bus_timeout_out <= 1'b1;
            tmo_cnt_q       <= 32'h0000_0000;
         end else begin
            tmo_cnt_q <= tmo_cnt_q + 32'h0000_0001;
         end
      end
   end

   // ****************************************************************
   // Register read-back
   // ****************************************************************
   always @(posedge clock_in) begin
      if (!resetn_in) begin
         rd_data_out <= 8'h00;
      end else if (rd_stb_in) begin
         case (rd_addr_in)
            `TAO_RA_STATUS:  rd_data_out <= status_q;
            `TAO_RA_CONFIG:  rd_data_out <= config_q;
            `TAO_RA_FS_HYST: rd_data_out <= hyst_q;
            `TAO_RA_CONSEC:  rd_data_out <= consec_q;
            default:         rd_data_out <= 8'h00;
         endcase
      end
   end

endmodule // tao_alarm_top

// ### logic/tao_hyst_cmp.v
// One channel of a fail-safe comparator with release hysteresis.
// Assumes temp, limit and hysteresis are unsigned whole degrees.
`timescale 1ns/1ps

module tao_hyst_cmp #(
   parameter W = 8
) (
   // Clock and reset
   input  wire         clock_in,
   input  wire         resetn_in,
   // Evaluation strobe and operands
   input  wire         update_in,
   input  wire [W-1:0] temp_in,
   input  wire [W-1:0] limit_in,
   input  wire [W-1:0] hyst_in,
   // Tripped state
   output wire         trip_out
);

   reg          trip_q;
   wire [W:0]   release_lvl;
   wire         at_release;

   // Nine bits so a hysteresis above the limit never wraps
   assign release_lvl = {1'b0, limit_in} - {1'b0, hyst_in};
   assign at_release  = release_lvl[W] | ({1'b0, temp_in} <= release_lvl);

   always @(posedge clock_in) begin
      if (!resetn_in) begin
         trip_q <= 1'b0;
      end else if (update_in) begin
         if (temp_in > limit_in) begin
            trip_q <= 1'b1;
         end else if (at_release) begin
            trip_q <= 1'b0;
         end
      end
   end

   assign trip_out = trip_q;

endmodule // tao_hyst_cmp

// ### pkg/tao_defs.vh
// Constants for the thermal alarm output block: register addresses,
// field positions, reset values and timing counts.
// Assumes an 8-bit register space reached through the serial interface.
`ifndef TAO_DEFS_VH
`define TAO_DEFS_VH

// ****************************************************************
// Register write addresses
// ****************************************************************
`define TAO_WA_CONFIG       8'h09
`define TAO_WA_LOC_HIGH     8'h0B
`define TAO_WA_LOC_LOW      8'h0C
`define TAO_WA_REM_HIGH     8'h0D
`define TAO_WA_REM_LOW      8'h0E
`define TAO_WA_ONE_SHOT     8'h0F
`define TAO_WA_REM_FS_LIM   8'h19
`define TAO_WA_LOC_FS_LIM   8'h20
`define TAO_WA_FS_HYST      8'h21
`define TAO_WA_CONSEC       8'h22

// ****************************************************************
// Register read addresses
// ****************************************************************
`define TAO_RA_STATUS       8'h02
`define TAO_RA_CONFIG       8'h03
`define TAO_RA_FS_HYST      8'h21
`define TAO_RA_CONSEC       8'h22

// ****************************************************************
// Field positions
// ****************************************************************
`define TAO_CFG_MASK_BIT    7
`define TAO_CFG_STANDBY_BIT 6
`define TAO_CFG_PINMODE_BIT 5
`define TAO_CON_TMO_EN_BIT  7
`define TAO_ST_LOC_HIGH     6
`define TAO_ST_LOC_LOW      5
`define TAO_ST_REM_HIGH     4
`define TAO_ST_REM_LOW      3
`define TAO_ST_OPEN         2

// ****************************************************************
// Reset values
// ****************************************************************
`define TAO_RST_CONFIG      8'h00
`define TAO_RST_LOC_HIGH    8'h55
`define TAO_RST_LOC_LOW     8'h00
`define TAO_RST_REM_HIGH    8'h55
`define TAO_RST_REM_LOW     8'h00
`define TAO_RST_FS_LIM      8'h6C
`define TAO_RST_FS_HYST     8'h0A
`define TAO_RST_CONSEC      8'h01

// ****************************************************************
// Timing
// ****************************************************************
`define TAO_CLK_KHZ         40000
`define TAO_BUS_TMO_MS      25
`define TAO_BUS_TMO_CYC     (`TAO_BUS_TMO_MS * `TAO_CLK_KHZ)

`endif

// ### verif/tao_alarm_assertions.sv
// Port-level checks of the thermal alarm output block.
// Assumes the top module ports as declared; bound at the foot.
`timescale 1ns/1ps
module tao_alarm_assertions #(
   parameter       W          = 8,
   parameter [6:0] DEV_ADDR   = 7'h4C,
   parameter       TMO_CYCLES = 20
) (
   // Clock, reset and requests
   input wire       clock_in,
   input wire       resetn_in,
   input wire       wr_stb_in,
   input wire       ara_req_in,
   input wire       conv_done_in,
   // Design outputs
   input wire       ara_ack_out,
   input wire [7:0] ara_byte_out,
   input wire       bus_timeout_out,
   input wire       conv_start_out,
   input wire       conv_abort_out,
   input wire       alarm_pin_o_out,
   input wire       alarm_pin_oe_out,
   input wire       overtemp_failsafe_n_o_out,
   input wire       overtemp_failsafe_n_oe_out
);
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (!resetn_in);
   // ****************************************
   // Alert response, pulse and pin checks
   // ****************************************
   sequence ara_answer_s;
      ara_ack_out ##1 (ara_byte_out == {DEV_ADDR, 1'b1});
   endsequence
   alarm_low_only_a: assert property (alarm_pin_o_out == 1'b0)
      else $error("alarm pin drives high");
   failsafe_low_only_a: assert property (overtemp_failsafe_n_o_out == 1'b0)
      else $error("fail-safe pin drives high");
   ara_ack_cause_a: assert property (ara_ack_out |-> ara_req_in)
      else $error("acknowledge without alert read");
   ara_byte_value_a: assert property (ara_ack_out |-> ara_answer_s)
      else $error("wrong alert response byte");
   start_pulse_a: assert property (conv_start_out |=> !conv_start_out)
      else $error("start pulse too long");
   abort_pulse_a: assert property (conv_abort_out |=> !conv_abort_out && !conv_start_out)
      else $error("abort not a lone pulse");
   timeout_pulse_a: assert property (bus_timeout_out |=> !bus_timeout_out)
      else $error("timeout pulse too long");
   alarm_rise_src_a: assert property ($rose(alarm_pin_oe_out) |->
      $past(conv_done_in) || $past(wr_stb_in) || $past(wr_stb_in, 2))
      else $error("alarm rose without result or write");
   failsafe_src_a: assert property ($changed(overtemp_failsafe_n_oe_out) |->
      $past(conv_done_in) || $past(wr_stb_in) || $past(wr_stb_in, 2))
      else $error("fail-safe moved without result");
endmodule // tao_alarm_assertions

bind tao_alarm_top tao_alarm_assertions #(.W(W), .DEV_ADDR(DEV_ADDR),
   .TMO_CYCLES(TMO_CYCLES)) u_tao_alarm_assertions (
   .clock_in(clock_in), .resetn_in(resetn_in), .wr_stb_in(wr_stb_in),
   .ara_req_in(ara_req_in), .conv_done_in(conv_done_in), .ara_ack_out(ara_ack_out),
   .ara_byte_out(ara_byte_out), .bus_timeout_out(bus_timeout_out),
   .conv_start_out(conv_start_out), .conv_abort_out(conv_abort_out),
   .alarm_pin_o_out(alarm_pin_o_out), .alarm_pin_oe_out(alarm_pin_oe_out),
   .overtemp_failsafe_n_o_out(overtemp_failsafe_n_o_out),
   .overtemp_failsafe_n_oe_out(overtemp_failsafe_n_oe_out));

// ### verif/tao_conv_model.sv
// Behavioural converter answering start pulses after a fixed latency.
// Assumes start and abort are one-cycle pulses from the alarm block.
`timescale 1ns/1ps
module tao_conv_model #(
   parameter LAT = 8
) (
   // Clock and reset
   input  wire       clock_in,
   input  wire       resetn_in,
   // Control from the alarm block
   input  wire       conv_start_in,
   input  wire       conv_abort_in,
   // Values to be measured
   input  wire [7:0] loc_set_in,
   input  wire [7:0] rem_set_in,
   input  wire       fault_set_in,
   // Results
   output reg        conv_done_out = 1'b0,
   output reg  [7:0] local_out = 8'h00,
   output reg  [7:0] remote_out = 8'h00,
   output wire       open_out
);
   integer cnt_q = -1;
   assign open_out = fault_set_in;
   always @(posedge clock_in) begin
      conv_done_out <= 1'b0;
      // Values only valid with done; flipped every cycle elsewhere so stale use shows
      local_out  <= ~local_out;
      remote_out <= ~remote_out;
      if (!resetn_in || conv_abort_in) begin
         cnt_q <= -1;
      end else if (conv_start_in) begin
         cnt_q <= LAT;
      end else if (cnt_q == 0) begin
         cnt_q         <= -1;
         conv_done_out <= 1'b1;
         local_out     <= loc_set_in;
         remote_out    <= rem_set_in;
      end else if (cnt_q > 0) begin
         cnt_q <= cnt_q - 1;
      end
   end
endmodule // tao_conv_model

// ### verif/testbench.sv
// Self-checking bench of the thermal alarm block and converter model.
// Assumes the checker and converter model are compiled first.
`timescale 1ns/1ps
module testbench;
   reg         clock_in = 1'b0;
   reg         resetn_in = 1'b0;
   reg         wr_stb = 1'b0, rd_stb = 1'b0, ara_req = 1'b0, ara_lost = 1'b0;
   reg         ara_done = 1'b0, bus_busy = 1'b0, bus_edge = 1'b0, fset = 1'b0;
   reg  [7:0]  wr_addr = 8'h00, wr_data = 8'h00, rd_addr = 8'h00;
   reg  [7:0]  lset = 8'h00, rset = 8'h00, st = 8'h00, q;
   wire [7:0]  rd_data, ara_byte, ltemp, rtemp;
   wire        ara_ack, tmo, cstart, cabort, cdone, openf, al_o, al_oe, fs_o, fs_oe;
   reg  [31:0] rng = 32'h0001_7971;
   reg         al = 1'b0, fl = 1'b0, fr = 1'b0, sl = 1'b0, sr = 1'b0;
   // Address fetched while pending, last open fault, cause still present
   reg         fe = 1'b0, of = 1'b0, cz = 1'b0;
   integer     error_cnt = 0, comparisons = 0, i, k;
   integer     hi_l = 85, hi_r = 85, lo = 0, fsl = 108, hy = 10, tl = 0, tr = 0, mode = 0;

   always #12.5 clock_in = ~clock_in;

   tao_alarm_top #(.TMO_CYCLES(20)) u_tao_alarm_top (
      .clock_in(clock_in), .resetn_in(resetn_in), .wr_stb_in(wr_stb),
      .wr_addr_in(wr_addr), .wr_data_in(wr_data), .rd_stb_in(rd_stb),
      .rd_addr_in(rd_addr), .rd_data_out(rd_data), .ara_req_in(ara_req),
      .ara_lost_in(ara_lost), .ara_done_in(ara_done), .ara_ack_out(ara_ack),
      .ara_byte_out(ara_byte), .bus_busy_in(bus_busy), .bus_edge_in(bus_edge),
      .bus_timeout_out(tmo), .conv_start_out(cstart), .conv_abort_out(cabort),
      .conv_done_in(cdone), .local_temp_in(ltemp), .remote_temp_in(rtemp),
      .open_fault_in(openf), .alarm_pin_o_out(al_o), .alarm_pin_oe_out(al_oe),
      .overtemp_failsafe_n_o_out(fs_o), .overtemp_failsafe_n_oe_out(fs_oe));

   tao_conv_model #(.LAT(8)) u_tao_conv_model (
      .clock_in(clock_in), .resetn_in(resetn_in), .conv_start_in(cstart),
      .conv_abort_in(cabort), .loc_set_in(lset), .rem_set_in(rset),
      .fault_set_in(fset), .conv_done_out(cdone), .local_out(ltemp),
      .remote_out(rtemp), .open_out(openf));

   // Quiet temperature, strictly inside both default limits
   function [7:0] qt();
      rng = rng ^ (rng << 13);
      rng = rng ^ (rng >> 17);
      rng = rng ^ (rng << 5);
      qt = 8'h01 + rng % 84;
   endfunction
   function hyst(input s, input integer t, input integer lim);
      hyst = (t > lim) ? 1'b1 : ((t <= lim - hy) ? 1'b0 : s);
   endfunction
   task chk(input string n, input logic [7:0] e, input logic [7:0] g);
      comparisons = comparisons + 1;
      if (g !== e) begin
         error_cnt = error_cnt + 1;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask
   task wr(input [7:0] a, input [7:0] d);
      @(posedge clock_in) begin wr_stb <= 1'b1; wr_addr <= a; wr_data <= d; end
      @(posedge clock_in) wr_stb <= 1'b0;
   endtask
   task rd(input [7:0] a, input [7:0] e);
      @(posedge clock_in) begin rd_stb <= 1'b1; rd_addr <= a; end
      @(posedge clock_in) rd_stb <= 1'b0;
      @(negedge clock_in) chk("rd_data", e, rd_data);
   endtask
   task ara(input lost, input ack);
      @(posedge clock_in) ara_req <= 1'b1;
      @(negedge clock_in) chk("ara_ack", {7'h00, ack}, {7'h00, ara_ack});
      @(posedge clock_in) begin ara_req <= 1'b0; ara_done <= ack; ara_lost <= lost; end
      @(negedge clock_in) if (ack) chk("ara_byte", {7'h4C, 1'b1}, ara_byte);
      @(posedge clock_in) begin ara_done <= 1'b0; ara_lost <= 1'b0; end
      fe = fe | (ack & ~lost);
   endtask
   task conv(input [7:0] l, input [7:0] r, input f);
      lset <= l; rset <= r; fset <= f;
      wr(8'h0F, rng[7:0]);
      k = 0;
      while (cdone !== 1'b1 && k < 40) begin @(negedge clock_in); k = k + 1; end
      repeat (2) @(posedge clock_in);
      @(negedge clock_in);
      tl = l; tr = r;
      q = {1'b0, tl > hi_l, tl <= lo, tr > hi_r, tr <= lo, f, 2'b00};
      st = st | q;
      of = f;
      if (q != 8'h00 && mode != 1) fe = 1'b0;
      al = al | (st != 8'h00);
      fl = hyst(fl, tl, fsl); fr = hyst(fr, tr, fsl);
      sl = hyst(sl, tl, hi_l); sr = hyst(sr, tr, hi_r);
      chk("done_seen", 8'h01, {7'h00, k < 40});
      chk("failsafe_oe", {7'h00, fl | fr}, {7'h00, fs_oe});
      chk("alarm_oe", {7'h00, mode == 2 ? sl | sr : mode == 0 && al}, {7'h00, al_oe});
   endtask
   task service;
      rd(8'h02, st);
      st = 8'h00;
      cz = tl > hi_l || tl <= lo || tr > hi_r || tr <= lo || of;
      // An earlier fetch lets the status read itself release the alarm
      if (fe && !cz) al = 1'b0;
      ara(1'b0, al);
      repeat (2) @(posedge clock_in);
      @(negedge clock_in);
      al = al && cz;
      fe = al;
      chk("alarm_oe", {7'h00, al}, {7'h00, al_oe});
   endtask
   task final_report;
      $display("errors %0d comparisons %0d", error_cnt, comparisons);
      if (error_cnt == 0 && comparisons > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge clock_in);
      error_cnt = error_cnt + 1;
      final_report;
   end

   initial begin
      repeat (2) @(posedge clock_in);
      resetn_in <= 1'b1;
      wr(8'h09, 8'h40);
      rd(8'h21, 8'h0A);
      rd(8'h22, 8'h01);
      rd(8'hEE, 8'h00);
      conv(qt(), qt(), 1'b0);
      conv(8'h56, qt(), 1'b0);
      ara(1'b1, 1'b1);
      ara(1'b0, 1'b1);
      conv(qt(), qt(), 1'b0);
      service;
      conv(qt(), qt(), 1'b1);
      conv(qt(), qt(), 1'b0);
      service;
      q = tl - 1;
      wr(8'h0B, q);
      hi_l = q; st[6] = 1'b1; al = 1'b1;
      fe = 1'b0;
      repeat (3) @(posedge clock_in);
      @(negedge clock_in) chk("alarm_oe", 8'h01, {7'h00, al_oe});
      wr(8'h0B, 8'h55);
      hi_l = 85;
      service;
      wr(8'h21, 8'h05);
      hy = 5;
      rd(8'h21, 8'h05);
      for (i = 0; i < 6; i = i + 1) begin
         q = (i % 3 == 0) ? 8'h6D : (i % 3 == 1) ? 8'h68 : 8'h67;
         if (i < 3) conv(q, qt(), 1'b0);
         else conv(qt(), q, 1'b0);
      end
      conv(qt(), qt(), 1'b0);
      service;
      wr(8'h09, 8'h60);
      mode = 2;
      conv(8'h56, qt(), 1'b0);
      ara(1'b0, 1'b0);
      conv(8'h51, qt(), 1'b0);
      conv(8'h50, qt(), 1'b0);
      wr(8'h09, 8'hC0);
      mode = 1;
      conv(8'h56, 8'h6D, 1'b0);
      wr(8'h09, 8'h80);
      k = 0;
      while (cstart !== 1'b1 && k < 20) begin @(negedge clock_in); k = k + 1; end
      wr(8'h09, 8'hC0);
      k = 0;
      while (cabort !== 1'b1 && k < 4) begin @(negedge clock_in); k = k + 1; end
      chk("abort", 8'h01, {7'h00, cabort});
      wr(8'h22, 8'h81);
      @(posedge clock_in) bus_busy <= 1'b1;
      repeat (10) @(posedge clock_in);
      bus_edge <= 1'b1;
      @(posedge clock_in) bus_edge <= 1'b0;
      k = 0;
      while (tmo !== 1'b1 && k < 40) begin @(negedge clock_in); k = k + 1; end
      chk("timeout", 8'h01, {7'h00, k >= 19 && k <= 22});
      @(posedge clock_in) bus_busy <= 1'b0;
      final_report;
   end
endmodule // testbench
